// *** inc/flash_cmd_pkg.sv ***
// package: constants and types for the flash command handler
// assumes a single 250 MHz clock and byte-wide command and reply streams
package flash_cmd_pkg;
  localparam int BLOCK_BITS = 4;
  localparam int OFFS_BITS = 6;
  localparam int ADDR_BITS = BLOCK_BITS + OFFS_BITS;
  localparam int REQ_LEN = 8;
  localparam int RSP_LEN = 8;
  localparam logic [7:0] CMD_ERASE = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_CHECK = 8'h05;
  localparam logic [7:0] CMD_CHECK_APPLY = 8'h06;
  localparam logic [7:0] RSP_CHECK_APPLY = 8'h86;
  localparam logic [7:0] STATUS_NO_IMAGE = 8'h01;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] IMAGE_MAGIC = 8'hA5;
  localparam logic [3:0] RESET_PULSE_CYCLES = 4'h8;
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    RECV = 3'b001,
    CHECK = 3'b010,
    REPLY = 3'b011,
    WIPE = 3'b100,
    ERASE_BLK = 3'b101,
    REBOOT = 3'b110,
    WR_BYTE = 3'b111
  } state_t;
endpackage

// *** inc/flash_mem_if.sv ***
// interface: port between handler and flash array
// assumes one clock domain
`timescale 1ns/1ps
interface flash_mem_if;
  logic we;
  logic [flash_cmd_pkg::ADDR_BITS-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// *** src/flash_array.sv ***
// file: flash byte array with registered read
// assumes writer applies bit-clearing semantics
`timescale 1ns/1ps
module flash_array (
  input wire logic clk,
  flash_mem_if.mem port
);
  logic [7:0] store [0:(1<<flash_cmd_pkg::ADDR_BITS)-1];
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end
endmodule

// *** src/flash_cmd_handler.sv ***
// file: flash command handler, check-and-apply image, erase and write
// assumes framed byte stream in, framed reply bytes out, same clock
//
// Overview of operation
// - invalid image on apply: reply to source endpoint
// - valid image: no reply, reset, run
// - reply command identifier is 0x86
// - status bit zero set means no image
// - block, offset, count zero; payload unused
// - write only clears one bits
// - only erase restores ones
// - erase covers one whole block
// - upgrade wipes the whole flash
// - only check-and-apply examines flash for valid image; CMD_CHECK is ignored
`timescale 1ns/1ps
module flash_cmd_handler (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  input wire logic inLast,
  input wire logic [7:0] inByte,
  input wire logic [7:0] srcEndpoint,
  output logic inReady,
  output logic outValid,
  output logic outLast,
  output logic [7:0] outByte,
  output logic [7:0] outEndpoint,
  input wire logic outReady,
  output logic rebootReq,
  output logic busy
);
  flash_cmd_pkg::state_t state;
  flash_mem_if mem();
  logic [7:0] req [0:flash_cmd_pkg::REQ_LEN-1];
  logic [3:0] cnt;
  logic [flash_cmd_pkg::ADDR_BITS-1:0] ptr;
  logic [3:0] rdDelay;
  logic [7:0] checkSum;
  logic imageOk;
  logic [3:0] rstCnt;
  logic [7:0] ep;

  flash_array u_array (
    .clk(clk),
    .port(mem)
  );

  function automatic logic [7:0] reply_byte(input logic [3:0] idx, input logic ok);
    case (idx)
      4'h0: reply_byte = flash_cmd_pkg::RSP_CHECK_APPLY;
      4'h1: reply_byte = ok ? 8'h00 : flash_cmd_pkg::STATUS_NO_IMAGE;
      default: reply_byte = 8'h00;
    endcase
  endfunction

  // frame layout: cmd, options, block, offsetHi, offset, countHi, count, data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= flash_cmd_pkg::IDLE;
      cnt <= 4'h0;
      ptr <= '0;
      rdDelay <= 4'h0;
      checkSum <= 8'h00;
      imageOk <= 1'b0;
      rstCnt <= 4'h0;
      ep <= 8'h00;
      mem.we <= 1'b0;
      mem.addr <= '0;
      mem.wdata <= 8'h00;
      inReady <= 1'b0;
      outValid <= 1'b0;
      outLast <= 1'b0;
      outByte <= 8'h00;
      outEndpoint <= 8'h00;
      rebootReq <= 1'b0;
      busy <= 1'b0;
      for (int i = 0; i < flash_cmd_pkg::REQ_LEN; i++) begin
        req[i] <= 8'h00;
      end
    end else begin
      mem.we <= 1'b0;
      case (state)
        flash_cmd_pkg::IDLE: begin
          inReady <= 1'b1;
          busy <= 1'b0;
          cnt <= 4'h0;
          if (inValid && inReady) begin
            req[0] <= inByte;
            ep <= srcEndpoint;
            cnt <= 4'h1;
            busy <= 1'b1;
            state <= flash_cmd_pkg::RECV;
          end
        end
        flash_cmd_pkg::RECV: begin
          if (inValid) begin
            if (cnt < 4'(flash_cmd_pkg::REQ_LEN)) begin
              req[cnt[2:0]] <= inByte;
              cnt <= cnt + 4'h1;
            end
            if (inLast) begin
              inReady <= 1'b0;
              ptr <= '0;
              rdDelay <= 4'h0;
              checkSum <= 8'h00;
              cnt <= 4'h0;
              case (req[0])
                flash_cmd_pkg::CMD_WRITE: begin
                  // read old byte first, then store the and of both
                  mem.addr <= {req[2][flash_cmd_pkg::BLOCK_BITS-1:0], req[4][flash_cmd_pkg::OFFS_BITS-1:0]};
                  state <= flash_cmd_pkg::WR_BYTE;
                end
                flash_cmd_pkg::CMD_ERASE: begin
                  ptr <= {req[2][flash_cmd_pkg::BLOCK_BITS-1:0], {flash_cmd_pkg::OFFS_BITS{1'b0}}};
                  state <= flash_cmd_pkg::ERASE_BLK;
                end
                flash_cmd_pkg::CMD_CHECK_APPLY: state <= flash_cmd_pkg::CHECK;
                default: state <= flash_cmd_pkg::IDLE;
              endcase
            end
          end
        end
        flash_cmd_pkg::CHECK: begin
          // scan whole flash: no marker byte is checked, sum must be zero
          mem.addr <= ptr;
          rdDelay <= {rdDelay[2:0], 1'b1};
          if (rdDelay[1]) begin
            checkSum <= checkSum + mem.rdata;
          end
          if (ptr != '1) begin
            ptr <= ptr + 1'b1;
          end
          // last address issued; its data arrive one cycle later
          if (rdDelay[1] && mem.addr == '1) begin
            cnt <= cnt + 4'h1;
          end
          if (cnt == 4'h1) begin
            cnt <= 4'h0;
            imageOk <= (checkSum + mem.rdata) == 8'h00;
            if ((checkSum + mem.rdata) == 8'h00) begin
              ptr <= '0;
              state <= flash_cmd_pkg::WIPE;
            end else begin
              state <= flash_cmd_pkg::REPLY;
            end
          end
        end
        flash_cmd_pkg::REPLY: begin
          if (!outValid || outReady) begin
            if (outValid && outLast) begin
              outValid <= 1'b0;
              outLast <= 1'b0;
              state <= flash_cmd_pkg::IDLE;
            end else begin
              outValid <= 1'b1;
              outEndpoint <= ep;
              outByte <= reply_byte(cnt, 1'b0);
              outLast <= (cnt == 4'(flash_cmd_pkg::RSP_LEN - 1));
              cnt <= cnt + 4'h1;
            end
          end
        end
        flash_cmd_pkg::WIPE: begin
          // upgrade erases every block before restart
          mem.addr <= ptr;
          mem.wdata <= flash_cmd_pkg::ERASED_BYTE;
          mem.we <= 1'b1;
          ptr <= ptr + 1'b1;
          if (ptr == '1) begin
            rstCnt <= flash_cmd_pkg::RESET_PULSE_CYCLES;
            state <= flash_cmd_pkg::REBOOT;
          end
        end
        flash_cmd_pkg::ERASE_BLK: begin
          mem.addr <= ptr;
          mem.wdata <= flash_cmd_pkg::ERASED_BYTE;
          mem.we <= 1'b1;
          ptr <= ptr + 1'b1;
          if (ptr[flash_cmd_pkg::OFFS_BITS-1:0] == '1) begin
            state <= flash_cmd_pkg::IDLE;
          end
        end
        flash_cmd_pkg::WR_BYTE: begin
          rdDelay <= {rdDelay[2:0], 1'b1};
          if (rdDelay[1]) begin
            mem.wdata <= mem.rdata & req[7];
            mem.we <= 1'b1;
            state <= flash_cmd_pkg::IDLE;
          end
        end
        flash_cmd_pkg::REBOOT: begin
          rebootReq <= 1'b1;
          rstCnt <= rstCnt - 4'h1;
          if (rstCnt == 4'h0) begin
            rebootReq <= 1'b0;
            state <= flash_cmd_pkg::IDLE;
          end
        end
        default: state <= flash_cmd_pkg::IDLE;
      endcase
    end
  end
endmodule

// *** sim/flash_cmd_handler_sva.sv ***
// checker: reply bytes and reboot pulse
// assumes bind onto flash_cmd_handler
`timescale 1ns/1ps
module flash_cmd_handler_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic outValid,
  input wire logic outLast,
  input wire logic [7:0] outByte,
  input wire logic [7:0] outEndpoint,
  input wire logic outReady,
  input wire logic rebootReq
);
  logic [2:0] idx;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) idx <= 3'h0;
    else if (outValid && outReady) idx <= outLast ? 3'h0 : idx + 3'h1;
  end
  property p_cmd; outValid && idx == 3'h0 |-> outByte == 8'h86; endproperty
  a_cmd: assert property (p_cmd) else $error("bad id");
  property p_stat; outValid && idx == 3'h1 |-> outByte == 8'h01; endproperty
  a_stat: assert property (p_stat) else $error("bad status");
  property p_zero; outValid && idx > 3'h1 |-> outByte == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("not zero");
  property p_last; outValid |-> outLast == (idx == 3'h7); endproperty
  a_last: assert property (p_last) else $error("bad length");
  property p_hold; outValid && !outReady |=> outValid && $stable(outByte); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_ep; outValid && $past(outValid) |-> $stable(outEndpoint); endproperty
  a_ep: assert property (p_ep) else $error("endpoint moved");
  property p_quiet; rebootReq |-> !outValid; endproperty
  a_quiet: assert property (p_quiet) else $error("reply on reboot");
  property p_pulse; $rose(rebootReq) |-> rebootReq [*8] ##1 !rebootReq; endproperty
  a_pulse: assert property (p_pulse) else $error("bad pulse");
  c_reply: cover property (outValid && outReady && outLast);
  c_stall: cover property (outValid && !outReady);
  c_boot: cover property ($rose(rebootReq));
endmodule
bind flash_cmd_handler flash_cmd_handler_sva i_sva (.*);

// *** sim/flash_requester_model.sv ***
// model: remote node sending frames, taking replies
// assumes falling-edge driving
`timescale 1ns/1ps
module flash_requester_model (
  input wire logic clk,
  input wire logic inReady,
  input wire logic outValid,
  input wire logic [7:0] outByte,
  input wire logic [7:0] outEndpoint,
  input wire logic rebootReq,
  output logic inValid,
  output logic inLast,
  output logic [7:0] inByte,
  output logic [7:0] srcEndpoint,
  output logic outReady
);
  logic slow = 1'b0;
  logic [7:0] rsp[$];
  logic [7:0] rspEp;
  int pulse = 0;
  initial begin
    inValid = 1'b0;
    inLast = 1'b0;
    inByte = 8'h00;
    srcEndpoint = 8'h00;
  end
  always @(negedge clk) outReady <= slow ? !outReady : 1'b1;
  always @(posedge clk) begin
    if (outValid && outReady) rsp.push_back(outByte);
    if (outValid && outReady) rspEp = outEndpoint;
    if (rebootReq) pulse++;
  end
  task automatic send(input logic [7:0] cmd, blk, off, cnt, dat, ep);
    logic [7:0] f[8];
    f = '{cmd, 8'h00, blk, 8'h00, off, 8'h00, cnt, dat};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      inValid = 1'b1;
      inByte = f[i];
      inLast = (i == 7);
      srcEndpoint = ep;
      while (!inReady) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    inValid = 1'b0;
    inLast = 1'b0;
    inByte = ~inByte;
    srcEndpoint = ~srcEndpoint;
  endtask
endmodule

// *** sim/flash_image_verify_install_tb_top.sv ***
// testbench: check-and-apply replies, reboot, flash rules
// assumes requester model and bound checker
`timescale 1ns/1ps
module flash_image_verify_install_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic inValid, inLast, inReady, outValid, outLast, outReady, rebootReq, busy;
  logic [7:0] inByte, srcEndpoint, outByte, outEndpoint;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  flash_cmd_handler i_dut (.*);
  flash_requester_model i_req (.*);
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] cmd, blk, off, dat);
    i_req.rsp.delete();
    i_req.pulse = 0;
    i_req.send(cmd, blk, off, {7'h00, cmd == 8'h02}, dat, blk ^ 8'h4C);
    repeat (3) @(posedge clk);
    while (busy) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask
  task automatic apply(input logic [7:0] ep, input int n);
    run(8'h06, 8'h00, ep, 8'h00);
    chk(i_req.pulse, n);
    chk(busy, 1'b0);
    chk(i_req.rsp.size(), n ? 0 : 8);
    if (n == 0) chk(i_req.rspEp, 8'h4C);
    for (int i = 0; i < 8 && n == 0; i++) chk(i_req.rsp[i], i ? {7'h00, i == 1} : 8'h86);
  endtask
  task automatic t_invalid;
    for (int b = 0; b < 16; b++) run(8'h01, b[7:0], 8'h00, 8'h00);
    run(8'h02, 8'h03, 8'h05, 8'hFE);
    i_req.slow = 1'b1;
    apply(8'h00, 0);
    i_req.slow = 1'b0;
    run(8'h02, 8'h03, 8'h05, 8'hFF);
    apply(8'h00, 0);
    $display("test invalid image done");
  endtask
  task automatic t_valid;
    run(8'h02, 8'h09, 8'h02, 8'h00);
    apply(8'h00, 8);
    run(8'h02, 8'h03, 8'h05, 8'hFE);
    apply(8'h00, 0);
    run(8'h01, 8'h03, 8'h00, 8'h00);
    apply(8'h00, 8);
    $display("test valid image done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    t_invalid;
    t_valid;
    end_sim;
  end
endmodule
